// ---- core/cie_pkg.sv ----
// Overview of operation
// - quotient divides extended_accum by byte register; remainder to register; 29 states.
// - software_trap pushes status, pc+1 high, pc+1 low; pc=0060h; sp minus 3.
// - interrupt_exit pops pc low then high, status from third byte, sp plus 3.
// - every return takes pc low from (sp) and pc high from (sp+1).
// - exit_and_skip restores pc, sp plus 2, then always skips next instruction.
// - absolute call pushes pc+3 high then low, pc=operand, sp minus 2.
// - table_subcall pushes pc+1; new pc from 128+2*index, high byte next.
// - skipped instruction idles 4, 8 or 14 states by length, 7 or 10 in the starred forms.
// - skipped two-byte starred instruction idles 7 states.
// - byte_rotate_right_carry: bits down, old carry to bit 7, bit 0 to carry; 8 states.
// - byte_shift_left zero-fills bit 0, bit 7 to carry; skip form skips on carry.
// - byte_shift_right zero-fills bit 7, bit 0 to carry; skip form skips on carry.
// - wide_rotate_left: bits up, old carry to bit 0, bit 15 to carry.
// - wide_shift_right zero-fills bit 15, bit 0 to carry.
// - reg_increment adds one in 4 states, skips on carry out.
// - reg_decrement subtracts one in 4 states, skips on borrow.
// - mem_increment bumps byte at V:offset in 16 states, skips on carry.
// - accum_twos_complement replaces A with complement plus one in 8 states.
// - test_clear_if_set_skip skips when flag set, clears it when found set.
package cie_pkg;
   localparam int ST_MUL = 32;
   localparam int ST_DIV = 29;
   localparam int ST_INC = 4;
   localparam int ST_MINC = 16;
   localparam int ST_SHIFT = 8;
   localparam int ST_NEG = 8;
   localparam int ST_CALL = 16;
   localparam int ST_BC_INDIRECT_SUBCALL = 17;
   localparam int ST_TABLE_SUBCALL = 16;
   localparam int ST_TRAP = 16;
   localparam int ST_RET = 10;
   localparam int ST_INTERRUPT_EXIT = 13;
   localparam int ST_TST = 8;
   localparam int SKP_1 = 4;
   localparam int SKP_2 = 8;
   localparam int SKP_2S = 7;
   localparam int SKP_3 = 14;
   localparam int SKP_3S = 10;
   localparam logic [15:0] TRAP_VEC = 16'h0060;
   localparam logic [15:0] TBL_BASE = 16'h0080;
   localparam int CY_BIT = 0;
   localparam logic [15:0] SP_RST = 16'h0000;
   localparam logic [15:0] PC_RST = 16'h0000;

   typedef logic [5:0] cie_cnt_t;
   typedef enum logic [1:0] {SEL_A, SEL_B, SEL_C} cie_rsel_t;
   typedef enum logic [2:0] {LEN_1, LEN_2, LEN_2S, LEN_3, LEN_3S} cie_len_t;
   typedef enum logic [4:0] {
      OP_NOP, OP_PRODUCT, OP_QUOTIENT, OP_REG_INC, OP_REG_DEC, OP_MEM_INC,
      OP_ACC_NEG, OP_ROT_R, OP_SHL, OP_SHR, OP_SHL_SKIP, OP_SHR_SKIP,
      OP_WIDE_ROTL, OP_WIDE_SHR, OP_CALL, OP_BC_CALL, OP_TABLE_CALL,
      OP_SOFT_TRAP, OP_SUB_EXIT, OP_EXIT_SKIP, OP_INT_EXIT,
      OP_TST_CLR_SKIP, OP_TST_NCLR_SKIP
   } cie_op_t;

   typedef struct packed {
      cie_op_t    op;
      cie_rsel_t  rsel;
      cie_len_t   len;
      logic [15:0] word;
      logic [4:0] idx;
      logic [7:0] off;
      logic [2:0] irf;
   } cie_cmd_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] ea;
      logic [7:0]  program_status_word;
      logic [7:0]  v;
      logic [7:0]  c;
      logic [7:0]  b;
      logic [7:0]  a;
   } cie_regs_t;

   function automatic logic [15:0] len_bytes(cie_len_t l);
      unique case (l)
         LEN_1:          return 16'h0001;
         LEN_2, LEN_2S:  return 16'h0002;
         default:        return 16'h0003;
      endcase
   endfunction

   function automatic cie_cnt_t skip_idle(cie_len_t l);
      unique case (l)
         LEN_1:   return cie_cnt_t'(SKP_1 - 1);
         LEN_2:   return cie_cnt_t'(SKP_2 - 1);
         LEN_2S:  return cie_cnt_t'(SKP_2S - 1);
         LEN_3:   return cie_cnt_t'(SKP_3 - 1);
         default: return cie_cnt_t'(SKP_3S - 1);
      endcase
   endfunction
endpackage

// ---- core/cie_exec.sv ----
`timescale 1ns/1ps
module cie_exec #(
   parameter int DM_AW = 8
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_cmd_valid,
   input  wire cie_pkg::cie_cmd_t i_cmd,
   output logic                 o_cmd_ready,
   input  wire logic [7:0]      i_irf_set,
   input  wire logic            i_ld_we,
   input  wire logic [DM_AW-1:0] i_ld_addr,
   input  wire logic [7:0]      i_ld_data,
   output logic [7:0]           o_ld_rdata,
   output cie_pkg::cie_regs_t   o_regs,
   output logic [7:0]           o_irf,
   output logic                 o_skip_pend
);
   import cie_pkg::*;

   // ----------------------------------------
   // architectural state
   // ----------------------------------------
   logic [7:0]  a_ff, b_ff, c_ff, v_ff, psw_ff, irf_ff, rd_ff;
   logic [7:0]  nxt_a, nxt_b, nxt_c, nxt_v, nxt_psw, nxt_irf;
   logic [15:0] ea_ff, sp_ff, pc_ff, nxt_ea, nxt_sp, nxt_pc;
   logic        skip_ff, nxt_skip;
   cie_cnt_t    cnt_ff, nxt_cnt;
   logic [7:0]  mem [0:(2**DM_AW)-1];

   logic [2:0]       we;
   logic [15:0]      wad [0:2];
   logic [7:0]       wdat [0:2];
   logic [7:0]       r2v, res8, irf_clr, m_sp0, m_sp1, m_sp2, m_wa, m_t0, m_t1;
   logic [15:0]      ta, ret_adr, lnk, quo;
   logic [7:0]       rem;
   logic             wr_r2, acc;
   cie_op_t          op;

   function automatic logic [DM_AW-1:0] ad(logic [15:0] x);
      return x[DM_AW-1:0];
   endfunction

   assign op = i_cmd.op;
   assign o_cmd_ready = (cnt_ff == '0);
   assign acc = i_cmd_valid && o_cmd_ready && !skip_ff;
   assign ta = TBL_BASE + {10'h000, i_cmd.idx, 1'b0};
   assign m_sp0 = mem[ad(sp_ff)];
   assign m_sp1 = mem[ad(sp_ff + 16'h0001)];
   assign m_sp2 = mem[ad(sp_ff + 16'h0002)];
   assign m_wa = mem[ad({v_ff, i_cmd.off})];
   assign m_t0 = mem[ad(ta)];
   assign m_t1 = mem[ad(ta + 16'h0001)];
   // divide by zero is undefined on the part; saturate rather than emit x
   assign quo = (r2v == '0) ? 16'hffff : ea_ff / {8'h00, r2v};
   assign rem = (r2v == '0) ? ea_ff[7:0] : 8'(ea_ff % {8'h00, r2v});

   // ----------------------------------------
   // next-state computation
   // ----------------------------------------
   always_comb begin
      nxt_a = a_ff;
      nxt_b = b_ff;
      nxt_c = c_ff;
      nxt_v = v_ff;
      nxt_psw = psw_ff;
      nxt_ea = ea_ff;
      nxt_sp = sp_ff;
      nxt_pc = pc_ff;
      nxt_skip = skip_ff;
      nxt_cnt = cnt_ff;
      we = '0;
      for (int i = 0; i < 3; i++) begin
         wad[i] = '0;
         wdat[i] = '0;
      end
      irf_clr = '0;
      wr_r2 = 1'b0;
      ret_adr = pc_ff + len_bytes(i_cmd.len);
      lnk = pc_ff + ((op == OP_CALL) ? len_bytes(LEN_3) :
                     (op == OP_BC_CALL) ? len_bytes(LEN_2) : len_bytes(LEN_1));
      unique case (i_cmd.rsel)
         SEL_B:   r2v = b_ff;
         SEL_C:   r2v = c_ff;
         default: r2v = a_ff;
      endcase
      res8 = r2v;
      if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - cie_cnt_t'(1);
      end else if (i_cmd_valid && skip_ff) begin
         nxt_skip = 1'b0;
         nxt_pc = ret_adr;
         nxt_cnt = skip_idle(i_cmd.len);
      end else if (i_cmd_valid) begin
         nxt_pc = ret_adr;
         nxt_cnt = cie_cnt_t'(ST_SHIFT - 1);
         unique case (op)
            OP_NOP: nxt_cnt = cie_cnt_t'(SKP_1 - 1);
            OP_PRODUCT: begin
               nxt_ea = {8'h00, a_ff} * {8'h00, r2v};
               nxt_cnt = cie_cnt_t'(ST_MUL - 1);
            end
            OP_QUOTIENT: begin
               nxt_ea = quo;
               res8 = rem;
               wr_r2 = 1'b1;
               nxt_cnt = cie_cnt_t'(ST_DIV - 1);
            end
            OP_REG_INC: begin
               res8 = r2v + 8'h01;
               wr_r2 = 1'b1;
               nxt_skip = (r2v == 8'hff);
               nxt_cnt = cie_cnt_t'(ST_INC - 1);
            end
            OP_REG_DEC: begin
               res8 = r2v - 8'h01;
               wr_r2 = 1'b1;
               nxt_skip = (r2v == 8'h00);
               nxt_cnt = cie_cnt_t'(ST_INC - 1);
            end
            OP_MEM_INC: begin
               we[0] = 1'b1;
               wad[0] = {v_ff, i_cmd.off};
               wdat[0] = m_wa + 8'h01;
               nxt_skip = (m_wa == 8'hff);
               nxt_cnt = cie_cnt_t'(ST_MINC - 1);
            end
            OP_ACC_NEG: nxt_a = ~a_ff + 8'h01;
            OP_ROT_R: begin
               res8 = {psw_ff[CY_BIT], r2v[7:1]};
               wr_r2 = 1'b1;
               nxt_psw[CY_BIT] = r2v[0];
            end
            OP_SHL, OP_SHL_SKIP: begin
               res8 = {r2v[6:0], 1'b0};
               wr_r2 = 1'b1;
               nxt_psw[CY_BIT] = r2v[7];
               nxt_skip = (op == OP_SHL_SKIP) && r2v[7];
            end
            OP_SHR, OP_SHR_SKIP: begin
               res8 = {1'b0, r2v[7:1]};
               wr_r2 = 1'b1;
               nxt_psw[CY_BIT] = r2v[0];
               nxt_skip = (op == OP_SHR_SKIP) && r2v[0];
            end
            OP_WIDE_ROTL: begin
               nxt_ea = {ea_ff[14:0], psw_ff[CY_BIT]};
               nxt_psw[CY_BIT] = ea_ff[15];
            end
            OP_WIDE_SHR: begin
               nxt_ea = {1'b0, ea_ff[15:1]};
               nxt_psw[CY_BIT] = ea_ff[0];
            end
            OP_CALL, OP_BC_CALL, OP_TABLE_CALL: begin
               we[1:0] = 2'b11;
               wad[0] = sp_ff - 16'h0001;
               wdat[0] = lnk[15:8];
               wad[1] = sp_ff - 16'h0002;
               wdat[1] = lnk[7:0];
               nxt_sp = sp_ff - 16'h0002;
               if (op == OP_CALL) begin
                  nxt_pc = i_cmd.word;
                  nxt_cnt = cie_cnt_t'(ST_CALL - 1);
               end else if (op == OP_BC_CALL) begin
                  nxt_pc = {b_ff, c_ff};
                  nxt_cnt = cie_cnt_t'(ST_BC_INDIRECT_SUBCALL - 1);
               end else begin
                  nxt_pc = {m_t1, m_t0};
                  nxt_cnt = cie_cnt_t'(ST_TABLE_SUBCALL - 1);
               end
            end
            OP_SOFT_TRAP: begin
               we = 3'b111;
               wad[0] = sp_ff - 16'h0001;
               wdat[0] = psw_ff;
               wad[1] = sp_ff - 16'h0002;
               wdat[1] = lnk[15:8];
               wad[2] = sp_ff - 16'h0003;
               wdat[2] = lnk[7:0];
               nxt_sp = sp_ff - 16'h0003;
               nxt_pc = TRAP_VEC;
               nxt_cnt = cie_cnt_t'(ST_TRAP - 1);
            end
            OP_SUB_EXIT, OP_EXIT_SKIP, OP_INT_EXIT: begin
               nxt_pc = {m_sp1, m_sp0};
               nxt_sp = sp_ff + 16'h0002;
               nxt_cnt = cie_cnt_t'(ST_RET - 1);
               if (op == OP_EXIT_SKIP) begin
                  nxt_skip = 1'b1;
               end
               if (op == OP_INT_EXIT) begin
                  nxt_psw = m_sp2;
                  nxt_sp = sp_ff + 16'h0003;
                  nxt_cnt = cie_cnt_t'(ST_INTERRUPT_EXIT - 1);
               end
            end
            OP_TST_CLR_SKIP, OP_TST_NCLR_SKIP: begin
               irf_clr[i_cmd.irf] = 1'b1;
               nxt_skip = irf_ff[i_cmd.irf] ^ (op == OP_TST_NCLR_SKIP);
            end
            default: nxt_cnt = cie_cnt_t'(SKP_1 - 1);
         endcase
      end
      if (wr_r2) begin
         unique case (i_cmd.rsel)
            SEL_B:   nxt_b = res8;
            SEL_C:   nxt_c = res8;
            default: nxt_a = res8;
         endcase
      end
      // a request raised in the clearing cycle survives
      nxt_irf = (irf_ff & ~irf_clr) | i_irf_set;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         a_ff <= '0;
         b_ff <= '0;
         c_ff <= '0;
         v_ff <= '0;
         psw_ff <= '0;
         irf_ff <= '0;
         ea_ff <= '0;
         sp_ff <= SP_RST;
         pc_ff <= PC_RST;
         skip_ff <= 1'b0;
         cnt_ff <= '0;
         rd_ff <= '0;
      end else begin
         a_ff <= nxt_a;
         b_ff <= nxt_b;
         c_ff <= nxt_c;
         v_ff <= nxt_v;
         psw_ff <= nxt_psw;
         irf_ff <= nxt_irf;
         ea_ff <= nxt_ea;
         sp_ff <= nxt_sp;
         pc_ff <= nxt_pc;
         skip_ff <= nxt_skip;
         cnt_ff <= nxt_cnt;
         rd_ff <= mem[i_ld_addr];
      end
   end

   // stack writes use distinct addresses; the load port is written last and wins over all of them
   always_ff @(posedge i_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (we[i]) begin
            mem[ad(wad[i])] <= wdat[i];
         end
      end
      if (i_ld_we && o_cmd_ready) begin
         mem[i_ld_addr] <= i_ld_data;
      end
   end

   assign o_regs = '{pc: pc_ff, sp: sp_ff, ea: ea_ff, program_status_word: psw_ff, v: v_ff,
                     c: c_ff, b: b_ff, a: a_ff};
   assign o_irf = irf_ff;
   assign o_skip_pend = skip_ff;
   assign o_ld_rdata = rd_ff;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_div_time;
      acc && op == OP_QUOTIENT |-> ##28 !o_cmd_ready ##1 o_cmd_ready;
   endproperty
   a_div_time: assert property (p_div_time) else $error("quotient timing wrong");

   property p_div_val;
      acc && op == OP_QUOTIENT && r2v != 8'h00 |=>
         ({16'h0000, ea_ff} * {24'h000000, $past(r2v)} + 32'($past(rem)))
            == {16'h0000, $past(ea_ff)};
   endproperty
   a_div_val: assert property (p_div_val) else $error("quotient value wrong");

   property p_trap;
      acc && op == OP_SOFT_TRAP |=> pc_ff == TRAP_VEC && sp_ff == $past(sp_ff) - 16'h0003;
   endproperty
   a_trap: assert property (p_trap) else $error("trap vector or sp wrong");

   property p_interrupt_exit;
      acc && op == OP_INT_EXIT |=> psw_ff == $past(m_sp2) && sp_ff == $past(sp_ff) + 16'h0003;
   endproperty
   a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit wrong");

   property p_exit_and_skip;
      acc && op == OP_EXIT_SKIP |=> skip_ff && pc_ff == {$past(m_sp1), $past(m_sp0)};
   endproperty
   a_exit_and_skip: assert property (p_exit_and_skip) else $error("skipping return wrong");

   property p_call;
      acc && op == OP_CALL |=> pc_ff == $past(i_cmd.word) && sp_ff == $past(sp_ff) - 16'h0002;
   endproperty
   a_call: assert property (p_call) else $error("call target or sp wrong");

   property p_skip1;
      i_cmd_valid && o_cmd_ready && skip_ff && i_cmd.len == LEN_1 |->
         ##1 !o_cmd_ready ##2 !o_cmd_ready ##1 o_cmd_ready;
   endproperty
   a_skip1: assert property (p_skip1) else $error("one-byte skip idle wrong");

   property p_rot;
      acc && op == OP_ROT_R |=> psw_ff[CY_BIT] == $past(r2v[0]);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate carry wrong");

   property p_inc_skip;
      acc && op == OP_REG_INC |=> skip_ff == ($past(r2v) == 8'hff);
   endproperty
   a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");

   property p_test_and_clear_skip;
      acc && op == OP_TST_CLR_SKIP && !i_irf_set[i_cmd.irf] |=>
         !irf_ff[$past(i_cmd.irf)] && skip_ff == $past(irf_ff[i_cmd.irf]);
   endproperty
   a_test_and_clear_skip: assert property (p_test_and_clear_skip) else $error("test and clear wrong");

   property p_skipped_quiet;
      i_cmd_valid && o_cmd_ready && skip_ff |=>
         a_ff == $past(a_ff) && ea_ff == $past(ea_ff) && sp_ff == $past(sp_ff) && !skip_ff;
   endproperty
   a_skipped_quiet: assert property (p_skipped_quiet) else $error("skip altered state");

   c_call: cover property (acc && op == OP_CALL);
   c_trap: cover property (acc && op == OP_SOFT_TRAP);
   c_skip: cover property (i_cmd_valid && o_cmd_ready && skip_ff);
   c_div: cover property (acc && op == OP_QUOTIENT);
endmodule // cie_exec

// ---- test/tb_cie_exec.sv ----
`timescale 1ns/1ps
module tb_cie_exec;
   import cie_pkg::*;
   // ---------------------------------------------
   // ports and model state
   // ---------------------------------------------
   logic              i_clk;
   logic              i_rst_n;
   logic              i_cmd_valid;
   cie_cmd_t          i_cmd;
   logic              o_cmd_ready;
   logic [7:0]        i_irf_set;
   logic              i_ld_we;
   logic [7:0]        i_ld_addr;
   logic [7:0]        i_ld_data;
   logic [7:0]        o_ld_rdata;
   cie_regs_t         o_regs;
   logic [7:0]        o_irf;
   logic              o_skip_pend;
   int                error_cnt = 0;
   int                checks = 0;
   int unsigned       rs = 30;
   int                m_pc = 0, m_sp = 0, m_ea = 0, m_psw = 0, m_a = 0, m_b = 0, m_c = 0;
   int                m_v = 0, m_irf = 0, m_skip = 0;
   int                mem [256];

   cie_exec #(.DM_AW(8)) i_dut (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_cmd_valid (i_cmd_valid),
      .i_cmd       (i_cmd),
      .o_cmd_ready (o_cmd_ready),
      .i_irf_set   (i_irf_set),
      .i_ld_we     (i_ld_we),
      .i_ld_addr   (i_ld_addr),
      .i_ld_data   (i_ld_data),
      .o_ld_rdata  (o_ld_rdata),
      .o_regs      (o_regs),
      .o_irf       (o_irf),
      .o_skip_pend (o_skip_pend)
   );

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic int rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return int'(rs & 32'h7fffffff);
   endfunction

   function automatic cie_cmd_t mk(cie_op_t op, cie_rsel_t s, cie_len_t l);
      cie_cmd_t c;
      c.op = op;
      c.rsel = s;
      c.len = l;
      c.word = 16'(rnd());
      c.idx = 5'(rnd());
      c.off = 8'(rnd());
      c.irf = 3'(rnd());
      return c;
   endfunction

   function automatic int get_r(cie_rsel_t s);
      return (s == SEL_A) ? m_a : ((s == SEL_B) ? m_b : m_c);
   endfunction

   task automatic set_r(cie_rsel_t s, int v);
      if (s == SEL_A) m_a = v & 32'hff;
      else if (s == SEL_B) m_b = v & 32'hff;
      else m_c = v & 32'hff;
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [15:0] got, int exp);
      checks++;
      if (got !== 16'(exp)) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, 16'(exp), got);
      end
   endtask

   task automatic push(int v);
      mem[(m_sp - 1) & 32'hff] = (v >> 8) & 32'hff;
      mem[(m_sp - 2) & 32'hff] = v & 32'hff;
      m_sp = (m_sp - 2) & 32'hffff;
   endtask

   // ---------------------------------------------
   // reference model: one instruction, returns its state count
   // ---------------------------------------------
   task automatic model(input cie_cmd_t c, output int n);
      int r, p, t, cy, lb;
      lb = (c.len == LEN_1) ? 1 : ((c.len == LEN_2 || c.len == LEN_2S) ? 2 : 3);
      r = get_r(c.rsel);
      p = m_pc;
      cy = m_psw & 1;
      n = 8;
      m_pc = (p + lb) & 32'hffff;
      if (m_skip != 0) begin
         m_skip = 0;
         n = (c.len == LEN_1) ? 4 : (c.len == LEN_2) ? 8 : (c.len == LEN_2S) ? 7 : 10;
         if (c.len == LEN_3) n = 14;
         return;
      end
      case (c.op)
         OP_NOP:       n = 4;
         OP_PRODUCT: begin
            n = 32;
            m_ea = m_a * r;
         end
         OP_QUOTIENT: begin
            n = 29;
            // divide by zero: all-ones quotient, remainder is the old low byte
            set_r(c.rsel, (r == 0) ? m_ea : m_ea % r);
            m_ea = (r == 0) ? 32'hffff : m_ea / r;
         end
         OP_REG_INC, OP_REG_DEC: begin
            n = 4;
            m_skip = (c.op == OP_REG_INC) ? (r == 32'hff) : (r == 0);
            set_r(c.rsel, (c.op == OP_REG_INC) ? r + 1 : r - 1);
         end
         OP_MEM_INC: begin
            n = 16;
            t = ((m_v << 8) | c.off) & 32'hff;
            m_skip = (mem[t] == 32'hff);
            mem[t] = (mem[t] + 1) & 32'hff;
         end
         OP_ACC_NEG:   m_a = (32'h100 - m_a) & 32'hff;
         OP_ROT_R: begin
            set_r(c.rsel, (r >> 1) | (cy << 7));
            cy = r & 1;
         end
         OP_SHL, OP_SHL_SKIP: begin
            set_r(c.rsel, r << 1);
            cy = r >> 7;
            m_skip = (c.op == OP_SHL_SKIP) && (cy != 0);
         end
         OP_SHR, OP_SHR_SKIP: begin
            set_r(c.rsel, r >> 1);
            cy = r & 1;
            m_skip = (c.op == OP_SHR_SKIP) && (cy != 0);
         end
         OP_WIDE_ROTL: begin
            t = m_ea >> 15;
            m_ea = ((m_ea << 1) | cy) & 32'hffff;
            cy = t;
         end
         OP_WIDE_SHR: begin
            cy = m_ea & 1;
            m_ea = m_ea >> 1;
         end
         OP_CALL: begin
            n = 16;
            push(p + 3);
            m_pc = c.word;
         end
         OP_BC_CALL: begin
            n = 17;
            push(p + 2);
            m_pc = (m_b << 8) | m_c;
         end
         OP_TABLE_CALL: begin
            n = 16;
            t = 32'h80 + 2 * c.idx;
            m_pc = mem[t] | (mem[t + 1] << 8);
            push(p + 1);
         end
         OP_SOFT_TRAP: begin
            n = 16;
            mem[(m_sp - 1) & 32'hff] = m_psw;
            m_sp = (m_sp - 1) & 32'hffff;
            push(p + 1);
            m_pc = 32'h0060;
         end
         OP_SUB_EXIT, OP_EXIT_SKIP, OP_INT_EXIT: begin
            n = (c.op == OP_INT_EXIT) ? 13 : 10;
            m_pc = mem[m_sp & 32'hff] | (mem[(m_sp + 1) & 32'hff] << 8);
            m_skip = (c.op == OP_EXIT_SKIP);
            if (c.op == OP_INT_EXIT) begin
               m_psw = mem[(m_sp + 2) & 32'hff];
               cy = m_psw & 1;
            end
            m_sp = (m_sp + ((c.op == OP_INT_EXIT) ? 3 : 2)) & 32'hffff;
         end
         default: begin
            t = (m_irf >> c.irf) & 1;
            m_skip = (c.op == OP_TST_CLR_SKIP) ? t : (t == 0);
            m_irf = m_irf & ~(1 << c.irf);
         end
      endcase
      m_psw = (m_psw & 32'hfe) | cy;
   endtask

   // ---------------------------------------------
   // bus tasks
   // ---------------------------------------------
   task automatic cmp();
      chk("pc", o_regs.pc, m_pc);
      chk("sp", o_regs.sp, m_sp);
      chk("ea", o_regs.ea, m_ea);
      chk("psw", {8'h00, o_regs.program_status_word}, m_psw);
      chk("a", {8'h00, o_regs.a}, m_a);
      chk("b", {8'h00, o_regs.b}, m_b);
      chk("c", {8'h00, o_regs.c}, m_c);
      chk("v", {8'h00, o_regs.v}, m_v);
      chk("irf", {8'h00, o_irf}, m_irf);
      chk("skip", {15'h0000, o_skip_pend}, m_skip);
   endtask

   // starts at a falling edge with the block idle; refused requests are offered while busy
   task automatic issue(input cie_cmd_t c);
      int n;
      i_cmd = c;
      i_cmd_valid = 1'b1;
      model(c, n);
      @(posedge i_clk);
      for (int k = 1; k < n; k++) begin
         @(negedge i_clk);
         chk("busy", {15'h0000, o_cmd_ready}, 0);
         i_cmd.op = OP_SOFT_TRAP;
         i_cmd_valid = (k < n - 1);
      end
      @(negedge i_clk);
      chk("ready", {15'h0000, o_cmd_ready}, 1);
      for (int w = 0; o_cmd_ready !== 1'b1; w++) begin
         if (w == 60) begin
            error_cnt++;
            tally_and_finish();
         end
         @(negedge i_clk);
      end
      cmp();
   endtask

   task automatic set_flags(logic [7:0] v);
      @(negedge i_clk);
      i_irf_set = v;
      m_irf = m_irf | v;
      @(negedge i_clk);
      i_irf_set = 8'h00;
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      i_rst_n = 1'b0;
      i_cmd_valid = 1'b0;
      i_cmd = '0;
      i_irf_set = 8'h00;
      i_ld_we = 1'b0;
      i_ld_addr = 8'h00;
      i_ld_data = 8'h00;
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      chk("ready", {15'h0000, o_cmd_ready}, 1);
      cmp();
      for (int a = 0; a < 256; a++) begin
         @(negedge i_clk);
         i_ld_we = 1'b1;
         i_ld_addr = 8'(a);
         i_ld_data = 8'(rnd());
         mem[a] = i_ld_data;
      end
      @(negedge i_clk);
      i_ld_we = 1'b0;
      issue(mk(OP_QUOTIENT, SEL_B, LEN_2));
      issue(mk(OP_REG_DEC, SEL_A, LEN_1));
      issue(mk(OP_REG_INC, SEL_C, LEN_1));
      issue(mk(OP_REG_INC, SEL_A, LEN_1));
      issue(mk(OP_PRODUCT, SEL_A, LEN_2));
      set_flags(8'hff);
      issue(mk(OP_TST_CLR_SKIP, SEL_A, LEN_2));
      issue(mk(OP_MEM_INC, SEL_A, LEN_2S));
      issue(mk(OP_TST_NCLR_SKIP, SEL_A, LEN_2));
      issue(mk(OP_CALL, SEL_A, LEN_3S));
      issue(mk(OP_EXIT_SKIP, SEL_A, LEN_1));
      issue(mk(OP_CALL, SEL_A, LEN_3));
      for (int k = 0; k < 23; k++) begin
         issue(mk(cie_op_t'(5'(k)), cie_rsel_t'(2'(rnd() % 3)), cie_len_t'(3'(rnd() % 5))));
      end
      for (int k = 0; k < 320; k++) begin
         if (k % 8 == 0) set_flags(8'(rnd()));
         issue(mk(cie_op_t'(5'(rnd() % 23)), cie_rsel_t'(2'(rnd() % 3)),
                  cie_len_t'(3'(rnd() % 5))));
      end
      for (int a = 0; a < 256; a++) begin
         @(negedge i_clk);
         i_ld_addr = 8'(a);
         @(negedge i_clk);
         chk("mem", {8'h00, o_ld_rdata}, mem[a]);
      end
      tally_and_finish();
   end
endmodule // tb_cie_exec
